/* design/uart_control_and_baud_gen.sv */
// Asynchronous serial interface: mode, status and baud registers with transmitter and receiver.
// Assumes an 8-bit register bus on the system clock and an asynchronous serial input pin.
module uart_control_and_baud_gen (
  input wire logic CLK_SYS, // System clock, 250 MHz.
  input wire logic NRST, // Asynchronous reset, active low.
  input wire logic [15:0] SFR_ADDR, // Register address.
  input wire logic [uart_pkg::DATA_WIDTH-1:0] SFR_WDATA, // Write data.
  input wire logic [uart_pkg::DATA_WIDTH-1:0] SFR_WMASK, // Bit write mask, all ones for byte.
  input wire logic SFR_WR, // Write strobe.
  input wire logic SFR_RD, // Read strobe.
  output logic [uart_pkg::DATA_WIDTH-1:0] SFR_RDATA, // Read data, one cycle after strobe.
  output logic TX_FIFO_READY, // Transmit data can be written.
  output logic SERIAL_OUT_PIN, // Serial transmit line, idles high.
  output logic SERIAL_OUT_SEL, // Transmit pin used by the serial function.
  input wire logic SERIAL_IN_PIN, // Serial receive line, asynchronous.
  output logic SERIAL_IN_SEL, // Receive pin used by the serial function.
  output logic RX_DONE_IRQ, // Receive-complete interrupt pulse.
  output logic TX_DONE_IRQ // Transmit-complete interrupt pulse.
);
  import uart_pkg::*;

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_t;

  logic [7:0] mode_r;
  logic [7:0] baud_r;
  logic [2:0] status_r;
  logic [7:0] rbuf_r;
  logic unread_r;
  logic rx_meta_r;
  logic rx_sync_r;
  logic rx_prev_r;
  tx_state_t tx_state_r;
  rx_state_t rx_state_r;
  logic [3:0] tx_tick_r;
  logic [2:0] tx_bit_r;
  logic tx_stop2_r;
  logic [7:0] tx_shift_r;
  logic tx_par_r;
  logic tx_line_r;
  logic [3:0] rx_tick_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_shift_r;
  logic rx_par_r;

  logic tx_en;
  logic rx_en;
  logic [1:0] parity_sel;
  logic char8;
  logic [2:0] last_bit;
  logic hit_mode;
  logic hit_baud;
  logic hit_data;
  logic byte_wr;
  logic buf_read;
  logic brg_tick;
  logic brg_en;
  logic fifo_valid;
  logic fifo_take;
  logic [7:0] fifo_data;
  logic [7:0] tx_char;
  logic tx_bit_end;
  logic rx_sample;
  logic rx_done;
  logic [7:0] rx_char;
  logic pe_now;
  logic fe_now;
  logic ove_now;

  // ****************************************************************
  // Mode decode and register access
  // ****************************************************************
  assign tx_en = mode_r[TRANSMIT_ENABLE_BIT];
  assign rx_en = mode_r[RECEIVE_ENABLE_BIT];
  assign parity_sel = mode_r[PARITY_SELECT_HI:PARITY_SELECT_LO];
  assign char8 = mode_r[CHAR_LENGTH_BIT];
  assign last_bit = char8 ? LAST_BIT_8 : LAST_BIT_7;
  assign hit_mode = (SFR_ADDR == ADDR_MODE);
  assign hit_baud = (SFR_ADDR == ADDR_BAUD);
  assign hit_data = (SFR_ADDR == ADDR_DATA);
  assign byte_wr = SFR_WR && (SFR_WMASK == BYTE_MASK);
  assign buf_read = SFR_RD && hit_data;
  assign SERIAL_IN_SEL = rx_en;
  assign SERIAL_OUT_SEL = tx_en;
  assign SERIAL_OUT_PIN = tx_line_r;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      mode_r <= MODE_RESET;
    end else if (SFR_WR && hit_mode) begin
      mode_r <= ((mode_r & ~SFR_WMASK) | (SFR_WDATA & SFR_WMASK)) & MODE_WMASK;
    end
  end

  // Partial-mask writes are bit instructions, which this register does not accept.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      baud_r <= BAUD_RESET;
    end else if (byte_wr && hit_baud) begin
      baud_r <= SFR_WDATA & BAUD_WMASK;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RD) begin
      unique case (SFR_ADDR)
        ADDR_MODE: SFR_RDATA <= mode_r;
        ADDR_STATUS: SFR_RDATA <= {5'h00, status_r};
        ADDR_BAUD: SFR_RDATA <= baud_r;
        ADDR_DATA: SFR_RDATA <= rbuf_r;
        default: SFR_RDATA <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Baud generator and transmit buffering
  // ****************************************************************
  // A prohibited divisor stops the generator instead of running at an undefined rate.
  assign brg_en = (tx_en || rx_en) && (baud_r[DIVISOR_SEL_HI:DIVISOR_SEL_LO] != DIVISOR_PROHIBITED);

  uart_baud_gen u_baud_gen (
    .clk(CLK_SYS),
    .nrst(NRST),
    .enable(brg_en),
    .prescale_sel(baud_r[PRESCALE_SEL_HI:PRESCALE_SEL_LO]),
    .divisor_sel(baud_r[DIVISOR_SEL_HI:DIVISOR_SEL_LO]),
    .tick(brg_tick)
  );

  assign fifo_take = tx_en && (tx_state_r == TX_IDLE);

  uart_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(CLK_SYS),
    .nrst(NRST),
    .in_valid(byte_wr && hit_data && tx_en),
    .in_ready(TX_FIFO_READY),
    .in_data(SFR_WDATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  assign tx_char = char8 ? fifo_data : {1'b0, fifo_data[6:0]};
  assign tx_bit_end = brg_tick && (tx_tick_r == TICKS_PER_BIT_M1);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tx_state_r <= TX_IDLE;
      tx_tick_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_stop2_r <= 1'b0;
      tx_shift_r <= DATA_RESET;
      tx_par_r <= 1'b0;
      tx_line_r <= 1'b1;
      TX_DONE_IRQ <= 1'b0;
    end else begin
      TX_DONE_IRQ <= 1'b0;
      if (brg_tick) begin
        tx_tick_r <= tx_tick_r + 4'h1;
      end
      unique case (tx_state_r)
        TX_IDLE: begin
          tx_line_r <= 1'b1;
          if (fifo_valid && fifo_take) begin
            tx_shift_r <= tx_char;
            unique case (parity_sel)
              PARITY_ODD: tx_par_r <= ~(^tx_char);
              PARITY_EVEN: tx_par_r <= ^tx_char;
              default: tx_par_r <= 1'b0;
            endcase
            tx_tick_r <= 4'h0;
            tx_line_r <= 1'b0;
            tx_state_r <= TX_START;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_line_r <= tx_shift_r[0];
            tx_bit_r <= 3'h0;
            tx_state_r <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift_r <= {1'b1, tx_shift_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r != last_bit) begin
              tx_line_r <= tx_shift_r[1];
            end else if (parity_sel != PARITY_NONE) begin
              tx_line_r <= tx_par_r;
              tx_state_r <= TX_PAR;
            end else begin
              tx_line_r <= 1'b1;
              tx_stop2_r <= mode_r[STOP_LENGTH_BIT];
              tx_state_r <= TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            tx_line_r <= 1'b1;
            tx_stop2_r <= mode_r[STOP_LENGTH_BIT];
            tx_state_r <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            if (tx_stop2_r) begin
              tx_stop2_r <= 1'b0;
            end else begin
              TX_DONE_IRQ <= 1'b1;
              tx_state_r <= TX_IDLE;
            end
          end
        end
      endcase
      // Disabling the transmitter abandons any frame and parks the line high.
      if (!tx_en) begin
        tx_state_r <= TX_IDLE;
        tx_line_r <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= SERIAL_IN_PIN;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  // Sampling happens mid-bit, sixteen generator ticks apart after a half-bit start check.
  assign rx_sample = brg_tick && (rx_tick_r == TICKS_PER_BIT_M1);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rx_state_r <= RX_IDLE;
      rx_tick_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_shift_r <= 8'h00;
      rx_par_r <= 1'b0;
    end else begin
      if (brg_tick) begin
        rx_tick_r <= rx_tick_r + 4'h1;
      end
      unique case (rx_state_r)
        RX_IDLE: begin
          if (rx_prev_r && !rx_sync_r) begin
            rx_tick_r <= 4'h0;
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          if (brg_tick && (rx_tick_r == HALF_BIT_M1)) begin
            rx_tick_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_state_r <= rx_sync_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_shift_r <= {rx_sync_r, rx_shift_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit) begin
              rx_state_r <= (parity_sel != PARITY_NONE) ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_sample) begin
            rx_par_r <= rx_sync_r;
            rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_state_r <= RX_IDLE;
          end
        end
      endcase
      if (!rx_en) begin
        rx_state_r <= RX_IDLE;
      end
    end
  end

  // ****************************************************************
  // Completion, status and receive buffer
  // ****************************************************************
  assign rx_done = rx_en && (rx_state_r == RX_STOP) && rx_sample;
  assign rx_char = char8 ? rx_shift_r : {1'b0, rx_shift_r[7:1]};
  assign fe_now = !rx_sync_r;
  assign ove_now = unread_r && !buf_read;

  always_comb begin
    unique case (parity_sel)
      PARITY_ODD: pe_now = ((^rx_char) ^ rx_par_r) != 1'b1;
      PARITY_EVEN: pe_now = ((^rx_char) ^ rx_par_r) != 1'b0;
      default: pe_now = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      status_r <= STATUS_RESET[2:0];
    end else if (rx_done) begin
      status_r[PARITY_ERROR_FLAG] <= pe_now;
      status_r[FRAMING_ERROR_FLAG] <= fe_now;
      status_r[OVERRUN_ERROR_FLAG] <= ove_now;
    end
  end

  // An overrun keeps the unread character; the newer one is dropped.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rbuf_r <= DATA_RESET;
      unread_r <= 1'b0;
    end else if (rx_done) begin
      if (!ove_now) begin
        rbuf_r <= rx_char;
      end
      unread_r <= 1'b1;
    end else if (buf_read) begin
      unread_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      RX_DONE_IRQ <= 1'b0;
    end else begin
      RX_DONE_IRQ <= rx_done &&
        !(mode_r[ERROR_IRQ_SUPPRESS] && (pe_now || fe_now || ove_now));
    end
  end

endmodule // uart_control_and_baud_gen

/* design/uart_pkg.sv */
// Shared constants of the serial control block: register addresses, field positions,
// reset values, frame codes and sizes.
// Assumes an 8-bit special function register bus with 16-bit addresses.
package uart_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [15:0] ADDR_MODE = 16'hFFA0;
  localparam logic [15:0] ADDR_STATUS = 16'hFFA1;
  localparam logic [15:0] ADDR_BAUD = 16'hFFA2;
  localparam logic [15:0] ADDR_DATA = 16'hFFA3;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hFF;
  localparam logic [7:0] MODE_WMASK = 8'hFE;
  localparam logic [7:0] BAUD_WMASK = 8'h7F;
  localparam logic [7:0] BYTE_MASK = 8'hFF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TRANSMIT_ENABLE_BIT = 7;
  localparam int RECEIVE_ENABLE_BIT = 6;
  localparam int PARITY_SELECT_HI = 5;
  localparam int PARITY_SELECT_LO = 4;
  localparam int CHAR_LENGTH_BIT = 3;
  localparam int STOP_LENGTH_BIT = 2;
  localparam int ERROR_IRQ_SUPPRESS = 1;
  localparam int PARITY_ERROR_FLAG = 2;
  localparam int FRAMING_ERROR_FLAG = 1;
  localparam int OVERRUN_ERROR_FLAG = 0;
  localparam int PRESCALE_SEL_HI = 6;
  localparam int PRESCALE_SEL_LO = 4;
  localparam int DIVISOR_SEL_HI = 3;
  localparam int DIVISOR_SEL_LO = 0;

  // ****************************************************************
  // Parity codes and divider limits
  // ****************************************************************
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ZERO = 2'h1;
  localparam logic [1:0] PARITY_ODD = 2'h2;
  localparam logic [1:0] PARITY_EVEN = 2'h3;
  localparam logic [3:0] DIVISOR_PROHIBITED = 4'hF;
  localparam logic [4:0] DIVISOR_BASE = 5'h10;

  // ****************************************************************
  // Frame timing and buffering
  // ****************************************************************
  localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hF;
  localparam logic [3:0] HALF_BIT_M1 = 4'h7;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam int DATA_WIDTH = 8;
  localparam int TX_FIFO_DEPTH = 16;

endpackage : uart_pkg

/* design/uart_baud_gen.sv */
// Baud generator: power-of-two prescaler followed by a 5-bit divide-by-16..31 counter.
// Assumes it runs on the system clock and that its settings are stable while enabled.
module uart_baud_gen (
  input wire logic clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic enable, // Generator runs while high.
  input wire logic [2:0] prescale_sel, // Source clock is clock over 2 to (code+1).
  input wire logic [3:0] divisor_sel, // Source clock divided by 16 plus this value.
  output logic tick // One-cycle pulse per generator period.
);
  import uart_pkg::*;

  logic [7:0] pre_cnt_r;
  logic [4:0] div_cnt_r;
  logic [7:0] pre_mask;
  logic src_tick;
  logic [4:0] div_last;

  assign pre_mask = BYTE_MASK >> (3'h7 - prescale_sel);
  assign src_tick = enable && ((pre_cnt_r & pre_mask) == pre_mask);
  assign div_last = DIVISOR_BASE + {1'b0, divisor_sel} - 5'h01;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_r <= 8'h00;
    end else if (!enable) begin
      pre_cnt_r <= 8'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_r <= 5'h00;
      tick <= 1'b0;
    end else if (!enable) begin
      div_cnt_r <= 5'h00;
      tick <= 1'b0;
    end else if (src_tick) begin
      tick <= (div_cnt_r == div_last);
      div_cnt_r <= (div_cnt_r == div_last) ? 5'h00 : div_cnt_r + 5'h01;
    end else begin
      tick <= 1'b0;
    end
  end

endmodule // uart_baud_gen

/* design/uart_fifo.sv */
// Synchronous FIFO with a registered output stage and valid/ready on both sides.
// Assumes one clock; the consumer may stall indefinitely.
module uart_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic in_valid, // Producer offers a word.
  output logic in_ready, // FIFO can take a word.
  input wire logic [WIDTH-1:0] in_data, // Word offered.
  output logic out_valid, // Output word is valid.
  input wire logic out_ready, // Consumer takes the output word.
  output logic [WIDTH-1:0] out_data // Output word, from a register.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign pop = (count_r != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_r[rd_ptr_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule // uart_fifo

/* tb/uart_far_end.sv */
// Far-end serial device: sends frames to the receiver, samples frames from the sender.
// Assumes tasks are called just after a clock edge, with the bit time in clocks.
module uart_far_end (
  input wire logic clk, // System clock.
  input wire logic tx_line, // Line from the sender.
  output logic rx_line // Line to the receiver, idles high.
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rx_line = 1'b1;

  task automatic put(input logic b, input int n);
    #1 rx_line = b;
    repeat (n) @(posedge clk);
  endtask

  // One stop bit only; idle of zero puts the next start where a second stop would be.
  task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic pb,
                      input logic sb, input int idle, input int bc);
    put(1'b0, bc);
    for (int i = 0; i < nb; i++) begin
      put(d[i], bc);
    end
    if (pe) begin
      put(pb, bc);
    end
    put(sb, bc);
    if (idle > 0) begin
      put(1'b1, idle * bc);
    end
  endtask

  task automatic recv(input int nb, input int bc, output logic [15:0] f, output logic ok);
    ok = 1'b0;
    f = 16'h0000;
    for (int t = 0; t < 30000 && !ok; t++) begin
      @(posedge clk);
      ok = !tx_line;
    end
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = tx_line;
      repeat (bc) @(posedge clk);
    end
  endtask
endmodule // uart_far_end

/* tb/uart_control_and_baud_gen_asserts.sv */
// Port checks of the serial control block.
// Assumes it is bound into the top module.
module uart_checker (
  input wire logic CLK_SYS, // Clock.
  input wire logic NRST, // Reset, low.
  input wire logic [15:0] SFR_ADDR, // Address.
  input wire logic SFR_RD, // Read strobe.
  input wire logic [uart_pkg::DATA_WIDTH-1:0] SFR_RDATA, // Read data.
  input wire logic SERIAL_OUT_PIN, // Line out.
  input wire logic SERIAL_OUT_SEL, // Pin owned.
  input wire logic TX_DONE_IRQ // Sent pulse.
);
  timeunit 1ns;
  timeprecision 100ps;
  import uart_pkg::*;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  property p_mode0;
    SFR_RD && SFR_ADDR == ADDR_MODE |=> !SFR_RDATA[0];
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode bit 0 set");
  property p_stat;
    SFR_RD && SFR_ADDR == ADDR_STATUS |=> SFR_RDATA[7:3] == 5'h00;
  endproperty
  a_stat: assert property (p_stat) else $error("status high bits set");
  property p_baud7;
    SFR_RD && SFR_ADDR == ADDR_BAUD |=> !SFR_RDATA[7];
  endproperty
  a_baud7: assert property (p_baud7) else $error("baud bit 7 set");
  property p_unmap;
    SFR_RD && (SFR_ADDR < ADDR_MODE || SFR_ADDR > ADDR_DATA) |=> SFR_RDATA == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold;
    !SFR_RD |=> $stable(SFR_RDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // A pin released by the serial function (select low two cycles) must rest high so nothing downstream sees a start bit.
  property p_idle;
    !SERIAL_OUT_SEL [*2] |-> SERIAL_OUT_PIN;
  endproperty
  a_idle: assert property (p_idle) else $error("line low while stopped");
  property p_end;
    TX_DONE_IRQ |-> SERIAL_OUT_SEL && $past(SERIAL_OUT_PIN);
  endproperty
  a_end: assert property (p_end) else $error("send done without stop");
  property p_start;
    $fell(SERIAL_OUT_PIN) |-> SERIAL_OUT_SEL ##1 !SERIAL_OUT_PIN [*8];
  endproperty
  a_start: assert property (p_start) else $error("bad start bit");
  c_end: cover property (TX_DONE_IRQ);
  c_start: cover property ($fell(SERIAL_OUT_PIN));
  c_stat: cover property (SFR_RD && SFR_ADDR == ADDR_STATUS);
endmodule // uart_checker

bind uart_control_and_baud_gen uart_checker uart_checker_inst (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .SFR_ADDR(SFR_ADDR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
  .SERIAL_OUT_SEL(SERIAL_OUT_SEL), .TX_DONE_IRQ(TX_DONE_IRQ));

/* tb/uart_control_and_baud_gen_bench.sv */
// Self-checking bench of the serial control block with a far-end serial device.
// Assumes one-cycle bus strobes and read data one cycle after the read edge.
module uart_control_and_baud_gen_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import uart_pkg::*;
  localparam int BIT0 = 512; // Baud 00: 32 clocks a tick, 16 ticks a bit.
  localparam int BIT1 = 1088; // Baud 11: 4 * 17 clocks a tick.
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] wmask = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rdy, opin, osel, ipin, isel, rxi, txi;
  logic [7:0] v;
  logic [15:0] f;
  logic ok;
  int failures = 0;
  int compares = 0;
  int rxn = 0;
  int txn = 0;
  int k;
  // ****************
  // Register table: address, data, mask, read back
  // ****************
  logic [39:0] rows [8] = '{{ADDR_MODE, 24'hFFFFFE}, {ADDR_MODE, 24'h00807E},
    {ADDR_STATUS, 24'hFFFF00}, {ADDR_BAUD, 24'hFFFF7F}, {ADDR_BAUD, 24'h000F7F},
    {16'hFFA4, 24'h55FF00}, {ADDR_BAUD, 24'h00FF00}, {ADDR_MODE, 24'h00FF00}};

  uart_control_and_baud_gen uart_control_and_baud_gen_inst (.CLK_SYS(clk), .NRST(nrst),
    .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WMASK(wmask), .SFR_WR(wr), .SFR_RD(rd),
    .SFR_RDATA(rdata), .TX_FIFO_READY(rdy), .SERIAL_OUT_PIN(opin), .SERIAL_OUT_SEL(osel),
    .SERIAL_IN_PIN(ipin), .SERIAL_IN_SEL(isel), .RX_DONE_IRQ(rxi), .TX_DONE_IRQ(txi));
  uart_far_end uart_far_end_inst (.clk(clk), .tx_line(opin), .rx_line(ipin));

  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    rxn <= rxn + int'(rxi === 1'b1);
    txn <= txn + int'(txi === 1'b1);
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic limit(input logic good);
    if (!good) begin
      failures++;
      give_verdict();
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wmask = m;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask

  task automatic rreg(input logic [15:0] a);
    @(posedge clk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    v = rdata;
  endtask

  task automatic rx(input logic [7:0] d, input int nb, input logic pe, input logic pb,
                    input logic sb, input logic [7:0] st);
    uart_far_end_inst.send(d, nb, pe, pb, sb, 1, BIT0);
    rreg(ADDR_STATUS);
    chk(12'(v), 12'(st));
  endtask

  task automatic txf(input int nb, input int bc, input logic [15:0] exp);
    uart_far_end_inst.recv(nb, bc, f, ok);
    limit(ok);
    chk(f[11:0], exp[11:0]);
    chk(12'(f[15:12]), 12'(exp[15:12]));
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    for (int a = 0; a < 4; a++) begin
      rreg(ADDR_MODE + 16'(a));
      chk(12'(v), (a == 3) ? 12'h0FF : 12'h000);
    end
    foreach (rows[i]) begin
      wreg(rows[i][39:24], rows[i][23:16], rows[i][15:8]);
      rreg(rows[i][39:24]);
      chk(12'(v), 12'(rows[i][7:0]));
    end
    chk(12'({osel, isel}), 12'h000);
    wreg(ADDR_MODE, 8'hBC, 8'hFF);
    wreg(ADDR_DATA, 8'hA5, 8'hFF);
    wreg(ADDR_DATA, 8'hA5, 8'hFF);
    // Two stop bits put the second frame's start bit at bit 12, not at bit 11.
    txf(13, BIT0, 16'({3'b011, ^8'hA5, 8'hA5, 1'b0}));
    for (int t = 0; t < 9000 && txn < 2; t++) @(posedge clk);
    limit(txn == 2);
    wreg(ADDR_BAUD, 8'h11, 8'hFF);
    wreg(ADDR_MODE, 8'h90, 8'hFF);
    chk(12'({osel, isel}), 12'h002);
    wreg(ADDR_DATA, 8'hFF, 8'hFF);
    wreg(ADDR_DATA, 8'h00, 8'hFF);
    txf(11, BIT1, 16'({3'b010, 7'h7F, 1'b0}));
    for (int t = 0; t < 30000 && txn < 4; t++) @(posedge clk);
    limit(txn == 4);
    wreg(ADDR_BAUD, 8'h00, 8'hFF);
    wreg(ADDR_MODE, 8'h6C, 8'hFF);
    chk(12'({osel, isel}), 12'h001);
    uart_far_end_inst.send(8'h3C, 8, 1'b1, ~^8'h3C, 1'b1, 0, BIT0);
    rx(8'h5A, 8, 1'b1, ~^8'h5A, 1'b1, 8'h01);
    rx(8'h5A, 8, 1'b1, ~^8'h5A, 1'b1, 8'h01);
    rreg(ADDR_DATA);
    chk(12'(v), 12'h03C);
    rx(8'hC3, 8, 1'b1, ~^8'hC3, 1'b1, 8'h00);
    rreg(ADDR_DATA);
    chk(12'(v), 12'h0C3);
    rx(8'hC3, 8, 1'b1, ^8'hC3, 1'b1, 8'h04);
    rreg(ADDR_DATA);
    rx(8'hC3, 8, 1'b1, ~^8'hC3, 1'b0, 8'h02);
    rreg(ADDR_DATA);
    wreg(ADDR_MODE, 8'h6E, 8'hFF);
    k = rxn;
    rx(8'hC3, 8, 1'b1, ^8'hC3, 1'b1, 8'h04);
    chk(12'(rxn), 12'(k));
    rreg(ADDR_DATA);
    wreg(ADDR_MODE, 8'h40, 8'hFF);
    rx(8'hFF, 7, 1'b0, 1'b0, 1'b1, 8'h00);
    rreg(ADDR_DATA);
    chk(12'(v), 12'h07F);
    wreg(ADDR_MODE, 8'h58, 8'hFF);
    rx(8'h55, 8, 1'b1, 1'b1, 1'b1, 8'h00);
    chk(12'(rxn), 12'h008);
    wreg(ADDR_MODE, 8'h80, 8'hFF);
    for (int i = 0; i < 18; i++) begin
      wreg(ADDR_DATA, 8'(i), 8'hFF);
      if (i == 16) begin
        chk(12'(rdy), 12'h001);
      end
    end
    chk(12'(rdy), 12'h000);
    // A reset in mid-frame with a full queue must bring the ready flag, the line and both pin selects back to idle.
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    chk(12'({rdy, opin, osel, isel}), 12'h00C);
    rreg(ADDR_MODE);
    chk(12'(v), 12'h000);
    rreg(ADDR_DATA);
    chk(12'(v), 12'h0FF);
    give_verdict();
  end
endmodule // uart_control_and_baud_gen_bench
